/* File: ewsc_pkg.sv */
package ewsc_pkg;

  // ****************************************
  // Configuration offsets
  // ****************************************
  localparam logic [7:0] OFF_EXT_BASE = 8'h14;
  localparam logic [7:0] OFF_SUBSYS = 8'h2c;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_PM_CAP = 8'h44;
  localparam logic [7:0] OFF_PM_CSR = 8'h48;
  localparam logic [7:0] OFF_SUBSYS_ACCESS = 8'hf8;

  // ****************************************
  // Extension window base fields
  // ****************************************
  localparam int EXT_BASE_LSB = 11;
  localparam int EXT_BASE_W = 21;
  localparam logic [20:0] EXT_BASE_RESET = 21'h000000;
  localparam logic [6:0] EXT_WINDOW_SIZE = 7'h00;
  localparam logic EXT_WINDOW_PREFETCHABLE = 1'b0;
  localparam logic [1:0] EXT_WINDOW_MEM_TYPE = 2'h0;
  localparam logic EXT_WINDOW_SPACE_INDICATOR = 1'b0;

  // ****************************************
  // Subsystem identification fields
  // ****************************************
  localparam int SUBSYS_DEVICE_LSB = 16;
  localparam int SUBSYS_VENDOR_LSB = 0;
  localparam logic [31:0] SUBSYS_RESET = 32'h00000000;

  // ****************************************
  // Capability list and power management
  // ****************************************
  localparam logic [7:0] CAP_PTR_VALUE = 8'h44;
  localparam logic [7:0] PM_CAP_ID = 8'h01;
  localparam logic [7:0] PM_NEXT_PTR = 8'h00;
  localparam logic [15:0] PM_CAPS_VALUE = 16'h0002;
  localparam int PM_STATE_LSB = 0;
  localparam logic [1:0] PM_STATE_RESET = 2'h0;

endpackage

/* File: ewsc_wr_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface ewsc_wr_if;
  logic wrEn;
  logic [7:0] addr;
  logic [3:0] byteEn;
  logic [31:0] data;

  modport source(output wrEn, output addr, output byteEn, output data);
  modport store(input wrEn, input addr, input byteEn, input data);
endinterface

`default_nettype wire

/* File: ewsc_subsys_store.sv */
`timescale 1ns/100ps
`default_nettype none

module ewsc_subsys_store
  import ewsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  ewsc_wr_if.store wrPort,
  input wire logic eepromLoad,
  input wire logic [31:0] eepromData,
  output logic [31:0] ident
);

  logic [31:0] next_ident;
  logic [31:0] mergedData;
  logic accessHit;

  // ****************************************
  // Byte lane merge
  // ****************************************
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : gLane
      assign mergedData[lane*8 +: 8] = wrPort.byteEn[lane] ?
        wrPort.data[lane*8 +: 8] : ident[lane*8 +: 8];
    end
  endgenerate

  // Writes to the own offset reach here but are ignored; only the access alias updates ident
  assign accessHit = wrPort.wrEn && ({wrPort.addr[7:2], 2'b00} == OFF_SUBSYS_ACCESS);

  always_comb begin
    next_ident = ident;
    // Loader wins over a coincident software write
    if (eepromLoad) begin
      next_ident = eepromData;
    end else if (accessHit) begin
      next_ident = mergedData;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ident <= SUBSYS_RESET;
    end else begin
      ident <= next_ident;
    end
  end

endmodule

`default_nettype wire

/* File: ewsc_window_decode.sv */
`timescale 1ns/100ps
`default_nettype none

module ewsc_window_decode
  import ewsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [20:0] basePtr,
  input wire logic decodeEnable,
  input wire logic memValid,
  input wire logic [31:0] memAddr,
  output logic hit,
  output logic [10:0] offset
);

  logic next_hit;
  logic [10:0] next_offset;

  always_comb begin
    next_hit = decodeEnable && memValid &&
      (memAddr[31:EXT_BASE_LSB] == basePtr);
    next_offset = next_hit ? memAddr[EXT_BASE_LSB-1:0] : 11'h000;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hit <= 1'b0;
      offset <= 11'h000;
    end else begin
      hit <= next_hit;
      offset <= next_offset;
    end
  end

endmodule

`default_nettype wire

/* File: ewsc_cfg_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module ewsc_cfg_regs
  import ewsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  output logic cfgRdValid,
  input wire logic eepromLoad,
  input wire logic [31:0] eepromData,
  input wire logic memDecodeEnable,
  input wire logic memValid,
  input wire logic [31:0] memAddr,
  output logic extWindowHit,
  output logic [10:0] extRegOffset,
  output logic [20:0] ext_window_base_ptr,
  output logic [31:0] subsysIdent,
  output logic [1:0] powerState
);

  // ****************************************
  // Internal signals
  // ****************************************
  logic [20:0] next_basePtr;
  logic [1:0] next_powerState;
  logic [31:0] next_rdData;
  logic next_rdValid;
  logic [7:0] dwordAddr;
  logic [31:0] baseWord;
  logic [31:0] identWord;
  logic [15:0] subsys_device_id;
  logic [15:0] subsys_vendor_id;

  ewsc_wr_if wrBus();

  assign dwordAddr = {cfgAddr[7:2], 2'b00};

  // Same write strobe feeds the ident store, which filters the alias itself
  assign wrBus.wrEn = cfgWrEn;
  assign wrBus.addr = cfgAddr;
  assign wrBus.byteEn = cfgByteEn;
  assign wrBus.data = cfgWrData;

  // ****************************************
  // Submodules
  // ****************************************
  ewsc_subsys_store uStore (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wrPort(wrBus),
    .eepromLoad(eepromLoad),
    .eepromData(eepromData),
    .ident(identWord)
  );

  ewsc_window_decode uDecode (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .basePtr(ext_window_base_ptr),
    .decodeEnable(memDecodeEnable),
    .memValid(memValid),
    .memAddr(memAddr),
    .hit(extWindowHit),
    .offset(extRegOffset)
  );

  assign subsysIdent = identWord;
  assign subsys_device_id = identWord[SUBSYS_DEVICE_LSB +: 16];
  assign subsys_vendor_id = identWord[SUBSYS_VENDOR_LSB +: 16];

  // ****************************************
  // Read views
  // ****************************************
  // Low bits are constants, so sizing by writing all ones reads FFFF F800h
  assign baseWord = {ext_window_base_ptr,
                     EXT_WINDOW_SIZE,
                     EXT_WINDOW_PREFETCHABLE,
                     EXT_WINDOW_MEM_TYPE,
                     EXT_WINDOW_SPACE_INDICATOR};

  // ****************************************
  // Writable state
  // ****************************************
  always_comb begin
    next_basePtr = ext_window_base_ptr;
    next_powerState = powerState;
    if (cfgWrEn && (dwordAddr == OFF_EXT_BASE)) begin
      // Byte 0 holds only constant bits, so its enable is ignored
      if (cfgByteEn[1]) begin
        next_basePtr[4:0] = cfgWrData[15:11];
      end
      if (cfgByteEn[2]) begin
        next_basePtr[12:5] = cfgWrData[23:16];
      end
      if (cfgByteEn[3]) begin
        next_basePtr[20:13] = cfgWrData[31:24];
      end
    end else if (cfgWrEn && (dwordAddr == OFF_PM_CSR)) begin
      if (cfgByteEn[0]) begin
        next_powerState = cfgWrData[PM_STATE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_window_base_ptr <= EXT_BASE_RESET;
      powerState <= PM_STATE_RESET;
    end else begin
      ext_window_base_ptr <= next_basePtr;
      powerState <= next_powerState;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // One cycle of latency keeps the read data straight from a flop
  always_comb begin
    next_rdValid = cfgRdEn;
    next_rdData = 32'h00000000;
    if (cfgRdEn) begin
      if (dwordAddr == OFF_EXT_BASE) begin
        next_rdData = baseWord;
      end else if (dwordAddr == OFF_SUBSYS) begin
        next_rdData = {subsys_device_id, subsys_vendor_id};
      end else if (dwordAddr == OFF_SUBSYS_ACCESS) begin
        next_rdData = {subsys_device_id, subsys_vendor_id};
      end else if (dwordAddr == OFF_CAP_PTR) begin
        next_rdData = {24'h000000, CAP_PTR_VALUE};
      end else if (dwordAddr == OFF_PM_CAP) begin
        next_rdData = {PM_CAPS_VALUE, PM_NEXT_PTR, PM_CAP_ID};
      end else if (dwordAddr == OFF_PM_CSR) begin
        next_rdData = {30'h00000000, powerState};
      end else begin
        next_rdData = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfgRdData <= 32'h00000000;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdData <= next_rdData;
      cfgRdValid <= next_rdValid;
    end
  end

endmodule

`default_nettype wire

/* File: ewsc_cfg_regs_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

module ewsc_cfg_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdValid,
  input wire logic eepromLoad,
  input wire logic [31:0] eepromData,
  input wire logic memDecodeEnable,
  input wire logic memValid,
  input wire logic [31:0] memAddr,
  input wire logic extWindowHit,
  input wire logic [10:0] extRegOffset,
  input wire logic [20:0] ext_window_base_ptr,
  input wire logic [31:0] subsysIdent
);
  // *****
  // Port checks
  // *****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_base_write: assert property (cfgWrEn && cfgAddr[7:2] == 6'h05 && cfgByteEn[3]
    |=> ext_window_base_ptr[20:13] == $past(cfgWrData[31:24])) else $error("base lane 3 lost");
  chk_base_size: assert property (cfgRdEn && cfgAddr[7:2] == 6'h05
    |=> cfgRdValid && cfgRdData[10:4] == 7'h00) else $error("base size bits set");
  chk_base_type: assert property (cfgRdEn && cfgAddr[7:2] == 6'h05
    |=> cfgRdData[3:0] == 4'h0) else $error("base type bits set");
  chk_ident_hold: assert property (!eepromLoad && !(cfgWrEn && cfgAddr[7:2] == 6'h3e)
    |=> $stable(subsysIdent)) else $error("ident changed without cause");
  chk_eeprom_load: assert property (eepromLoad
    |=> subsysIdent == $past(eepromData)) else $error("ident not loaded");
  chk_alias_write: assert property (cfgWrEn && cfgAddr[7:2] == 6'h3e && cfgByteEn == 4'hf
    && !eepromLoad |=> subsysIdent == $past(cfgWrData)) else $error("alias write lost");
  chk_ident_read: assert property (cfgRdEn && cfgAddr[7:2] == 6'h0b
    |=> cfgRdData == $past(subsysIdent)) else $error("ident read wrong");
  chk_cap_ptr: assert property (cfgRdEn && cfgAddr[7:2] == 6'h0d
    |=> cfgRdData == 32'h00000044) else $error("pointer read wrong");
  chk_pm_cap: assert property (cfgRdEn && cfgAddr[7:2] == 6'h11
    |=> cfgRdData == 32'h00020001) else $error("pm dword wrong");
  chk_pm_state: assert property (cfgRdEn && cfgAddr[7:2] == 6'h12
    |=> cfgRdValid && cfgRdData[31:2] == 30'h0) else $error("pm state upper bits set");
  chk_window_hit: assert property (memValid && memDecodeEnable
    && memAddr[31:11] == ext_window_base_ptr |=> extWindowHit
    && extRegOffset == $past(memAddr[10:0])) else $error("window miss");
endmodule

bind ewsc_cfg_regs ewsc_cfg_checker ewsc_cfg_checker_inst (.*);

`default_nettype wire

/* File: ewsc_host.sv */
`timescale 1ns/100ps
`default_nettype none

module ewsc_host (
  input wire logic clk_sys,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdValid,
  output logic cfgWrEn,
  output logic cfgRdEn,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWrData
);
  // *****
  // Config cycles
  // *****
  initial begin
    cfgWrEn = 1'b0;
    cfgRdEn = 1'b0;
    cfgAddr = 8'h00;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    cfgWrEn = 1'b1;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    @(negedge clk_sys);
    cfgWrEn = 1'b0;
    // Released data flips so stale values cannot pass
    cfgWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output bit ok);
    ok = 1'b0;
    d = 32'h0;
    @(negedge clk_sys);
    cfgRdEn = 1'b1;
    cfgAddr = a;
    @(negedge clk_sys);
    cfgRdEn = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (cfgRdValid === 1'b1) begin
        ok = 1'b1;
        d = cfgRdData;
      end else @(negedge clk_sys);
    end
  endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk_sys, rstn, cfgWrEn, cfgRdEn, cfgRdValid, eepromLoad, memDecodeEnable, memValid;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn;
  logic [31:0] cfgWrData, cfgRdData, eepromData, memAddr, subsysIdent;
  logic extWindowHit;
  logic [10:0] extRegOffset;
  logic [20:0] ext_window_base_ptr;
  logic [1:0] powerState;
  int err_total = 0;
  int check_count = 0;

  ewsc_cfg_regs ewsc_cfg_regs_inst (.*);
  ewsc_host ewsc_host_inst (.*);

  // *****
  // Checks
  // *****
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bit ok;
    ewsc_host_inst.rd(a, d, ok);
    // A missing answer ends the run at once
    if (!ok) begin
      err_total++;
      print_verdict();
    end else begin
      cmp("cfg read", e, d);
    end
  endtask
  task automatic memchk(input logic en, input logic [31:0] a, input logic h);
    @(negedge clk_sys);
    memDecodeEnable = en;
    memValid = 1'b1;
    memAddr = a;
    @(negedge clk_sys);
    memValid = 1'b0;
    memAddr = ~a;
    cmp("window hit", {31'h0, h}, {31'h0, extWindowHit});
    cmp("window offset", h ? {21'h0, a[10:0]} : 32'h0, {21'h0, extRegOffset});
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    rstn = 1'b0;
    eepromLoad = 1'b0;
    eepromData = 32'h0;
    memDecodeEnable = 1'b0;
    memValid = 1'b0;
    memAddr = 32'h0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'b1;
    rdchk(8'h14, 32'h00000000);
    rdchk(8'h2c, 32'h00000000);
    ewsc_host_inst.wr(8'h14, 4'hf, 32'hffffffff);
    cmp("base pointer", 32'h001fffff, {11'h0, ext_window_base_ptr});
    rdchk(8'h14, 32'hfffff800);
    ewsc_host_inst.wr(8'h14, 4'h4, 32'h00000000);
    rdchk(8'h14, 32'hff00f800);
    ewsc_host_inst.wr(8'h34, 4'hf, 32'h00000000);
    rdchk(8'h34, 32'h00000044);
    ewsc_host_inst.wr(8'h2c, 4'hf, 32'h12345678);
    rdchk(8'h2c, 32'h00000000);
    @(negedge clk_sys);
    eepromLoad = 1'b1;
    eepromData = 32'habcd1234;
    @(negedge clk_sys);
    eepromLoad = 1'b0;
    eepromData = 32'h5432edcb;
    rdchk(8'h2c, 32'habcd1234);
    cmp("device id", 32'h0000abcd, {16'h0, subsysIdent[31:16]});
    ewsc_host_inst.wr(8'hf8, 4'hf, 32'h5a5a0c0c);
    rdchk(8'h2c, 32'h5a5a0c0c);
    rdchk(8'h44, 32'h00020001);
    ewsc_host_inst.wr(8'h48, 4'h1, 32'h00000003);
    cmp("power state", 32'h00000003, {30'h0, powerState});
    rdchk(8'h48, 32'h00000003);
    rdchk(8'h60, 32'h00000000);
    ewsc_host_inst.wr(8'h14, 4'hf, 32'h12345800);
    memchk(1'b1, 32'h12345fff, 1'b1);
    memchk(1'b1, 32'h12346000, 1'b0);
    memchk(1'b0, 32'h12345abc, 1'b0);
    // Mid-run reset must clear the pointer and the ident again
    @(negedge clk_sys) rstn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    cmp("base pointer", 32'h00000000, {11'h0, ext_window_base_ptr});
    rdchk(8'h14, 32'h00000000);
    rdchk(8'h2c, 32'h00000000);
    rdchk(8'h48, 32'h00000000);
    print_verdict();
  end
endmodule

`default_nettype wire
